/* src/cwg_regs.vh */
// Purpose: named offsets, bit positions and reset values for the
//          conditional write guard register bank
// Assumes: 6-bit control bus address, 8-bit data
// Notes:   included by the top-level design file only
`ifndef CWG_REGS_VH
`define CWG_REGS_VH

// register offsets on the control bus
`define CWG_ADDR_W 6
`define CWG_OFF_CONFIG 6'h01
`define CWG_OFF_INT_COND 6'h02
`define CWG_OFF_INT_MASK 6'h03
`define CWG_OFF_TX_STATE 6'h04
`define CWG_OFF_RX_COND_A 6'h09
`define CWG_OFF_RX_COND_B 6'h0A
`define CWG_OFF_INT_CMP 6'h1A
`define CWG_OFF_TX_CMP 6'h1B
`define CWG_OFF_RX_A_CMP 6'h1C
`define CWG_OFF_RX_B_CMP 6'h1D
`define CWG_OFF_CMT_CMP 6'h1F
`define CWG_OFF_CMT_COND 6'h20

// bit positions inside the interrupt condition register
`define CWG_BIT_WRITE_INHIBIT 3
`define CWG_BIT_LINK_ERR 4

// reset values
`define CWG_RST_ZERO 8'h00
`define CWG_RST_INT_COND 8'h10
`define CWG_RST_TX_STATE 8'h00
`define CWG_RST_LEM_COUNT 8'h00

// counter constants
`define CWG_LEM_ONE 8'h01

`endif

/* src/cwg_guard.v */
// Purpose: per-register merge of a host write with a compare register
// Assumes: purely combinational, used once per guarded register
// Notes:   only bits matching the compare register take the write data
module cwg_guard
#(
  parameter W = 8
)
(
  input wire [W-1:0] cur_i,
  input wire [W-1:0] cmp_i,
  input wire [W-1:0] wdata_i,
  input wire wr_i,
  output wire [W-1:0] next_o,
  output wire inhibit_o
);

  // bits still equal to what the host last saw
  wire [W-1:0] match;

  assign match = ~(cur_i ^ cmp_i);

  // matching bits follow the write, others keep their value
  assign next_o = wr_i ? ((cur_i & ~match) | (wdata_i & match)) : cur_i;

  // any changed-since-read bit blocks part of the write
  assign inhibit_o = wr_i & ~(&match);

endmodule

/* src/cwg_top.v */
// Purpose: guarded condition registers, compare registers, config,
//          interrupt mask and link error threshold flag
// Assumes: one clock, synchronous active-high reset, one-cycle
//          read/write strobes on the control bus
// Notes:
// Notes on behaviour
// [R01] write blocked by change sets write-inhibit flag
// [R02] mismatching bits versus compare register not written
// [R03] guarding covers offsets 02, 04, 09, 0A, 20
// [R04] compare partners 1A, 1B, 1C, 1D, 1F
// [R05] write-inhibit flag cleared only by host write
// [R06] config writes ignored while scrubbing
// [R07] link-error flag set when counter reaches zero
// [R08] reset zeroes counter and sets link-error flag
// [R09] interrupt low when condition and mask both set
// [R10] matching bits of a guarded write update normally
`include "cwg_regs.vh"
module cwg_top
(
  input wire REF_CLK_I,
  input wire RESET_I,
  input wire [5:0] CBUS_ADDR_I,
  input wire [7:0] CBUS_WDATA_I,
  input wire CBUS_WR_I,
  input wire CBUS_RD_I,
  input wire SCRUB_ACTIVE_I,
  input wire [7:0] INT_COND_SET_I,
  input wire [7:0] RX_COND_A_SET_I,
  input wire [7:0] RX_COND_B_SET_I,
  input wire [7:0] CMT_COND_SET_I,
  input wire LEM_DEC_I,
  input wire LEM_LOAD_I,
  input wire [7:0] LEM_LOAD_VALUE_I,
  output reg [7:0] CBUS_RDATA_O,
  output reg CBUS_ACK_O,
  output reg [7:0] CONFIG_O,
  output reg [7:0] TX_STATE_O,
  output reg INT_N_O
);

  // address match helper
  function hit;
    input [5:0] addr;
    input [5:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // guarded condition registers
  reg [7:0] interrupt_condition;
  reg [7:0] transmit_state;
  reg [7:0] receive_condition_a;
  reg [7:0] receive_condition_b;
  reg [7:0] connection_mgmt_condition;
  // compare registers
  reg [7:0] interrupt_condition_compare;
  reg [7:0] transmit_state_compare;
  reg [7:0] receive_condition_a_compare;
  reg [7:0] receive_condition_b_compare;
  reg [7:0] connection_mgmt_condition_compare;
  // plain registers
  reg [7:0] configuration_setup;
  reg [7:0] interrupt_mask_bank;
  // link error monitor counter
  reg [7:0] lem_count;

  // write strobes per guarded register
  wire wr_int = CBUS_WR_I & hit(CBUS_ADDR_I, `CWG_OFF_INT_COND); // see [R03]
  wire wr_tsr = CBUS_WR_I & hit(CBUS_ADDR_I, `CWG_OFF_TX_STATE);
  wire wr_rca = CBUS_WR_I & hit(CBUS_ADDR_I, `CWG_OFF_RX_COND_A);
  wire wr_rcb = CBUS_WR_I & hit(CBUS_ADDR_I, `CWG_OFF_RX_COND_B);
  wire wr_cmt = CBUS_WR_I & hit(CBUS_ADDR_I, `CWG_OFF_CMT_COND);

  // merged values and inhibit indications from the guards
  wire [7:0] g_int;
  wire [7:0] g_tsr;
  wire [7:0] g_rca;
  wire [7:0] g_rcb;
  wire [7:0] g_cmt;
  wire [4:0] inh;

  // each guarded register against its compare partner, see [R04]
  cwg_guard #(.W(8)) u_g_int
  (
    .cur_i(interrupt_condition),
    .cmp_i(interrupt_condition_compare),
    .wdata_i(CBUS_WDATA_I),
    .wr_i(wr_int),
    .next_o(g_int),
    .inhibit_o(inh[0])
  );
  cwg_guard #(.W(8)) u_g_tsr
  (
    .cur_i(transmit_state),
    .cmp_i(transmit_state_compare),
    .wdata_i(CBUS_WDATA_I),
    .wr_i(wr_tsr),
    .next_o(g_tsr),
    .inhibit_o(inh[1])
  );
  cwg_guard #(.W(8)) u_g_rca
  (
    .cur_i(receive_condition_a),
    .cmp_i(receive_condition_a_compare),
    .wdata_i(CBUS_WDATA_I),
    .wr_i(wr_rca),
    .next_o(g_rca),
    .inhibit_o(inh[2])
  );
  cwg_guard #(.W(8)) u_g_rcb
  (
    .cur_i(receive_condition_b),
    .cmp_i(receive_condition_b_compare),
    .wdata_i(CBUS_WDATA_I),
    .wr_i(wr_rcb),
    .next_o(g_rcb),
    .inhibit_o(inh[3])
  );
  cwg_guard #(.W(8)) u_g_cmt
  (
    .cur_i(connection_mgmt_condition),
    .cmp_i(connection_mgmt_condition_compare),
    .wdata_i(CBUS_WDATA_I),
    .wr_i(wr_cmt),
    .next_o(g_cmt),
    .inhibit_o(inh[4])
  );

  // counter step reaching zero is the threshold event
  wire lem_hit = LEM_DEC_I & ~LEM_LOAD_I & (lem_count == `CWG_LEM_ONE);

  // hardware set vector for the interrupt condition register
  reg [7:0] int_set;
  reg [7:0] next_int_cond;
  reg [7:0] next_rdata;

  // sets win over host clears in the same cycle
  always @*
  begin
    int_set = INT_COND_SET_I;
    int_set[`CWG_BIT_WRITE_INHIBIT] = |inh; // see [R01] [R02]
    int_set[`CWG_BIT_LINK_ERR] = lem_hit; // see [R07]
    next_int_cond = g_int | int_set; // see [R05] [R10]
  end

  // read data multiplexer, unmapped reads return zero
  always @*
  begin
    case (CBUS_ADDR_I)
      `CWG_OFF_CONFIG: next_rdata = configuration_setup;
      `CWG_OFF_INT_COND: next_rdata = interrupt_condition;
      `CWG_OFF_INT_MASK: next_rdata = interrupt_mask_bank;
      `CWG_OFF_TX_STATE: next_rdata = transmit_state;
      `CWG_OFF_RX_COND_A: next_rdata = receive_condition_a;
      `CWG_OFF_RX_COND_B: next_rdata = receive_condition_b;
      `CWG_OFF_INT_CMP: next_rdata = interrupt_condition_compare;
      `CWG_OFF_TX_CMP: next_rdata = transmit_state_compare;
      `CWG_OFF_RX_A_CMP: next_rdata = receive_condition_a_compare;
      `CWG_OFF_RX_B_CMP: next_rdata = receive_condition_b_compare;
      `CWG_OFF_CMT_CMP: next_rdata = connection_mgmt_condition_compare;
      `CWG_OFF_CMT_COND: next_rdata = connection_mgmt_condition;
      default: next_rdata = `CWG_RST_ZERO;
    endcase
  end

  // guarded and condition registers
  always @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      interrupt_condition <= `CWG_RST_INT_COND; // see [R08]
      transmit_state <= `CWG_RST_TX_STATE;
      receive_condition_a <= `CWG_RST_ZERO;
      receive_condition_b <= `CWG_RST_ZERO;
      connection_mgmt_condition <= `CWG_RST_ZERO;
    end
    else
    begin
      interrupt_condition <= next_int_cond;
      transmit_state <= g_tsr; // see [R02] [R10]
      receive_condition_a <= g_rca | RX_COND_A_SET_I;
      receive_condition_b <= g_rcb | RX_COND_B_SET_I;
      connection_mgmt_condition <= g_cmt | CMT_COND_SET_I;
    end
  end

  // compare, configuration and mask registers
  always @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      interrupt_condition_compare <= `CWG_RST_ZERO;
      transmit_state_compare <= `CWG_RST_ZERO;
      receive_condition_a_compare <= `CWG_RST_ZERO;
      receive_condition_b_compare <= `CWG_RST_ZERO;
      connection_mgmt_condition_compare <= `CWG_RST_ZERO;
      configuration_setup <= `CWG_RST_ZERO;
      interrupt_mask_bank <= `CWG_RST_ZERO; // see [R09]
    end
    else if (CBUS_WR_I)
    begin
      case (CBUS_ADDR_I)
        `CWG_OFF_INT_CMP: interrupt_condition_compare <= CBUS_WDATA_I;
        `CWG_OFF_TX_CMP: transmit_state_compare <= CBUS_WDATA_I;
        `CWG_OFF_RX_A_CMP: receive_condition_a_compare <= CBUS_WDATA_I;
        `CWG_OFF_RX_B_CMP: receive_condition_b_compare <= CBUS_WDATA_I;
        `CWG_OFF_CMT_CMP:
          connection_mgmt_condition_compare <= CBUS_WDATA_I;
        `CWG_OFF_INT_MASK: interrupt_mask_bank <= CBUS_WDATA_I;
        `CWG_OFF_CONFIG:
        begin
          // dropped while scrubbing, see [R06]
          if (!SCRUB_ACTIVE_I)
            configuration_setup <= CBUS_WDATA_I;
        end
        default: ;
      endcase
    end
  end

  // link error monitor down-counter, stops at zero
  always @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      lem_count <= `CWG_RST_LEM_COUNT; // see [R08]
    else if (LEM_LOAD_I)
      lem_count <= LEM_LOAD_VALUE_I;
    else if (LEM_DEC_I && (lem_count != `CWG_RST_LEM_COUNT))
      lem_count <= lem_count - `CWG_LEM_ONE;
  end

  // registered bus answer, interrupt and mirrored outputs
  always @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      CBUS_RDATA_O <= `CWG_RST_ZERO;
      CBUS_ACK_O <= 1'b0;
      CONFIG_O <= `CWG_RST_ZERO;
      TX_STATE_O <= `CWG_RST_TX_STATE;
      INT_N_O <= 1'b1;
    end
    else
    begin
      if (CBUS_RD_I)
        CBUS_RDATA_O <= next_rdata;
      CBUS_ACK_O <= CBUS_RD_I | CBUS_WR_I;
      CONFIG_O <= configuration_setup;
      TX_STATE_O <= transmit_state;
      INT_N_O <= ~(|(interrupt_condition & interrupt_mask_bank)); // see [R09]
    end
  end

endmodule

/* verification/cwg_monitor.sv */
// Purpose: port checks for the write guard bank
// Assumes: one clock, sync reset
// Notes: flag history learnt from reads of 02
module cwg_monitor (
  input logic REF_CLK_I,
  input logic RESET_I,
  input logic [5:0] CBUS_ADDR_I,
  input logic [7:0] CBUS_WDATA_I,
  input logic CBUS_WR_I,
  input logic CBUS_RD_I,
  input logic SCRUB_ACTIVE_I,
  input logic [7:0] CBUS_RDATA_O,
  input logic CBUS_ACK_O,
  input logic [7:0] CONFIG_O,
  input logic INT_N_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] stk; // flags 4:3 seen set
  logic rd02; // read of 02 answered now
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff RESET_I;
  // learn flags from reads, forget on writes to 02
  always @(posedge REF_CLK_I)
  begin
    rd02 <= CBUS_RD_I && CBUS_ADDR_I == 6'h02;
    if (RESET_I)
      stk <= 2'h2;
    else if (CBUS_WR_I && CBUS_ADDR_I == 6'h02)
      stk <= 2'h0;
    else if (rd02)
      stk <= CBUS_RDATA_O[4:3];
  end
  property p_ack; CBUS_WR_I || CBUS_RD_I |=> CBUS_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_hold; !CBUS_RD_I |=> $stable(CBUS_RDATA_O); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unm;
    CBUS_RD_I && CBUS_ADDR_I == 6'h1E |=> CBUS_RDATA_O == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_rst; $fell(RESET_I) |-> INT_N_O && CONFIG_O == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_msk;
    CBUS_WR_I && CBUS_ADDR_I == 6'h03 && CBUS_WDATA_I == 8'h00
    ##1 !(CBUS_WR_I && CBUS_ADDR_I == 6'h03) |=> INT_N_O;
  endproperty
  a_msk: assert property (p_msk) else $error("masked irq");
  property p_scr;
    SCRUB_ACTIVE_I && CBUS_WR_I && CBUS_ADDR_I == 6'h01
    |=> ##1 $stable(CONFIG_O);
  endproperty
  a_scr: assert property (p_scr) else $error("scrub write");
  property p_cfg;
    !SCRUB_ACTIVE_I && CBUS_WR_I && CBUS_ADDR_I == 6'h01
    |=> ##1 CONFIG_O == $past(CBUS_WDATA_I, 2);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config lost");
  property p_stk;
    CBUS_RD_I && CBUS_ADDR_I == 6'h02
    |=> (CBUS_RDATA_O[4:3] & $past(stk)) == $past(stk);
  endproperty
  a_stk: assert property (p_stk)
    else $error("flag lost");
  c_scr: cover property (SCRUB_ACTIVE_I && CBUS_WR_I);
  c_int: cover property ($fell(INT_N_O));
  c_inh: cover property (rd02 && CBUS_RDATA_O[3]);
endmodule

/* verification/cwg_host.sv */
// Purpose: host model driving the control bus
// Assumes: one request at a time, on the falling edge
// Notes: idle bus inverted so stale values never look valid
module cwg_host (
  input logic clk_i,
  output logic [5:0] addr_o = 6'h00,
  output logic [7:0] wdata_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // one strobe cycle, then scramble the idle bus
  task automatic xfer(input logic w, input logic [5:0] a,
    input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule

/* verification/testbench.sv */
// Purpose: self-checking bench for the write guard bank
// Assumes: 4 ns clock, reset held six cycles
// Notes: reads queue their expected byte, a watcher compares on ack
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, scrub = 0, dec = 0, ld = 0, rd_seen = 0;
  logic [7:0] sets [0:3] = '{default: 8'h00}; // event pulses
  logic [7:0] ldv = 8'h02, rdata, cfg, txs, s, c, w, m;
  logic [5:0] a, go [0:3] = '{6'h04, 6'h09, 6'h0A, 6'h20};
  logic [5:0] co [0:3] = '{6'h1B, 6'h1C, 6'h1D, 6'h1F};
  logic wr, rd, ack, intn;
  logic [7:0] wd, q [$]; // expected read data
  logic [31:0] seed = 32'hE4AB;
  int err_total = 0, check_count = 0, cyc = 0;
  cwg_host h_u (.clk_i(clk), .addr_o(a), .wdata_o(wd), .wr_o(wr), .rd_o(rd));
  cwg_top dut_u (.REF_CLK_I(clk), .RESET_I(rst), .CBUS_ADDR_I(a),
    .CBUS_WDATA_I(wd), .CBUS_WR_I(wr), .CBUS_RD_I(rd),
    .SCRUB_ACTIVE_I(scrub), .INT_COND_SET_I(sets[0]),
    .RX_COND_A_SET_I(sets[1]), .RX_COND_B_SET_I(sets[2]),
    .CMT_COND_SET_I(sets[3]), .LEM_DEC_I(dec), .LEM_LOAD_I(ld),
    .LEM_LOAD_VALUE_I(ldv), .CBUS_RDATA_O(rdata), .CBUS_ACK_O(ack),
    .CONFIG_O(cfg), .TX_STATE_O(txs), .INT_N_O(intn));
  initial forever #2 clk = ~clk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd_reg(input logic [5:0] ad, input logic [7:0] e);
    q.push_back(e);
    h_u.xfer(1'b0, ad, 8'h00);
  endtask
  task automatic conclude();
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // remember which ack answers a read
  always @(posedge clk)
    rd_seen <= rd;
  // compare read data, cut a hang short
  always @(negedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      conclude();
    end
    if (ack === 1'b1 && rd_seen === 1'b1)
      chk(rdata, q.pop_front());
  end
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 0;
    rd_reg(6'h02, 8'h10);
    rd_reg(6'h03, 8'h00);
    rd_reg(6'h1E, 8'h00);
    h_u.xfer(1'b1, 6'h02, 8'h00);
    rd_reg(6'h02, 8'h18);
    h_u.xfer(1'b1, 6'h1A, 8'h18);
    h_u.xfer(1'b1, 6'h02, 8'h00);
    rd_reg(6'h02, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      s = rnd();
      if (i == 0)
        h_u.xfer(1'b1, 6'h04, s);
      else
      begin
        @(negedge clk) sets[i] = s;
        @(negedge clk) sets[i] = 8'h00;
      end
      c = i[0] ? s : rnd();
      w = rnd();
      m = s ^ c;
      h_u.xfer(1'b1, co[i], c);
      h_u.xfer(1'b1, go[i], w);
      rd_reg(go[i], (w & ~m) | (s & m));
      // mirrored transmit state output follows the guarded register
      if (i == 0)
        chk(txs, (w & ~m) | (s & m));
      rd_reg(6'h02, m ? 8'h08 : 8'h00);
      h_u.xfer(1'b1, 6'h1A, m ? 8'h08 : 8'h00);
      h_u.xfer(1'b1, 6'h02, 8'h00);
    end
    // event pulse in the same cycle as a host clear: the set wins
    fork
      h_u.xfer(1'b1, 6'h02, 8'h00);
      begin
        @(negedge clk) sets[0] = 8'h01;
        @(negedge clk) sets[0] = 8'h00;
      end
    join
    rd_reg(6'h02, 8'h01);
    h_u.xfer(1'b1, 6'h1A, 8'h01);
    h_u.xfer(1'b1, 6'h02, 8'h00);
    rd_reg(6'h02, 8'h00);
    @(negedge clk) ld = 1;
    @(negedge clk) ld = 0;
    for (int k = 0; k < 2; k++)
    begin
      @(negedge clk) dec = 1;
      @(negedge clk) dec = 0;
      rd_reg(6'h02, k ? 8'h10 : 8'h00);
    end
    h_u.xfer(1'b1, 6'h03, 8'h10);
    repeat (2) @(negedge clk);
    chk({7'h00, intn}, 8'h00);
    h_u.xfer(1'b1, 6'h03, 8'h00);
    repeat (2) @(negedge clk);
    chk({7'h00, intn}, 8'h01);
    s = rnd();
    h_u.xfer(1'b1, 6'h01, s);
    scrub = 1;
    h_u.xfer(1'b1, 6'h01, ~s);
    rd_reg(6'h01, s);
    chk(cfg, s);
    scrub = 0;
    h_u.xfer(1'b1, 6'h01, ~s);
    rd_reg(6'h01, ~s);
    repeat (4) @(negedge clk);
    conclude();
  end
endmodule
bind cwg_top cwg_monitor mon_u (.REF_CLK_I, .RESET_I, .CBUS_ADDR_I,
  .CBUS_WDATA_I, .CBUS_WR_I, .CBUS_RD_I, .SCRUB_ACTIVE_I, .CBUS_RDATA_O,
  .CBUS_ACK_O, .CONFIG_O, .INT_N_O);
